// [fsl_pkg.sv]
// Package: command codes, status flag positions, bus offsets and timing for the flash host
package fsl_pkg;
  // Flash command codes
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] CMD_RESUME       = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] CMD_SET_BLOCK    = 8'h01;
  localparam logic [7:0] CMD_SET_PERM     = 8'hF1;
  localparam logic [7:0] CMD_CLEAR_LOCKS  = 8'hD0;
  localparam logic [7:0] CMD_WRITE_SETUP  = 8'h40;
  // Status flag positions
  localparam int SR_READY      = 7;
  localparam int SR_ERASE_SUSP = 6;
  localparam int SR_ERASE_ERR  = 5;
  localparam int SR_WRITE_ERR  = 4;
  localparam int SR_SUPPLY_ERR = 3;
  localparam int SR_WRITE_SUSP = 2;
  localparam int SR_PROT_ERR   = 1;
  // Wishbone register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h4;
  localparam logic [3:0] REG_DATA   = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  // Control field: operation code in bits 3:0, write of nonzero starts it
  localparam int CTRL_OP_W = 4;
  localparam logic [3:0] OP_NONE       = 4'h0;
  localparam logic [3:0] OP_SUSPEND    = 4'h1;
  localparam logic [3:0] OP_RESUME     = 4'h2;
  localparam logic [3:0] OP_SET_BLOCK  = 4'h3;
  localparam logic [3:0] OP_SET_PERM   = 4'h4;
  localparam logic [3:0] OP_CLEAR_LOCK = 4'h5;
  localparam logic [3:0] OP_CLEAR_STAT = 4'h6;
  localparam logic [3:0] OP_READ_STAT  = 4'h7;
  localparam logic [3:0] OP_WRITE_WORD = 4'h8;
  localparam logic [3:0] OP_READ_ARRAY = 4'h9;
  // Status register bit positions
  localparam int ST_BUSY      = 8;
  localparam int ST_SUSP_OK   = 9;
  localparam int ST_RDY_PIN   = 10;
  localparam int ST_REJECT    = 11;
  localparam int ST_LOCK_UNK  = 12;
  // Bus strobe timing: 100 ns each phase at 20 MHz
  localparam int CLK_NS    = 50;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // Least spacing from resume to next suspend
  localparam int RESUME_GAP_NS  = 20000;
  localparam int RESUME_GAP_CYC = (RESUME_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] RESET_DATA = 16'h0000;
  typedef enum {FSL_IDLE, FSL_SETUP, FSL_STROBE, FSL_HOLD, FSL_GAP} fsl_bus_e;
endpackage

// [fsl_sync.sv]
// Three-flop input synchroniser with agreement filter
`timescale 1ns/100ps
module fsl_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin and filtered level
  input  wire logic pin_i,
  output logic      level_o
);
  logic [2:0] sh_q, sh_d;
  logic       lvl_q, lvl_d;

  always_comb begin
    sh_d  = {sh_q[1:0], pin_i};
    // First flop only feeds the second
    lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_q  <= 3'b000;
      lvl_q <= 1'b0;
    end else begin
      sh_q  <= sh_d;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;
endmodule // fsl_sync

// [fsl_host.sv]
// Flash host: suspend, resume and lock command sequencer behind a Wishbone slave
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module fsl_host import fsl_pkg::*; #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Flash bus
  output logic      [ADDR_W-1:0] fl_addr_o,
  input  wire logic [DATA_W-1:0] fl_dq_i,
  output logic      [DATA_W-1:0] fl_dq_o,
  output logic                   fl_dq_oe_o,
  output logic                   fl_ce_n_o,
  output logic                   fl_oe_n_o,
  output logic                   fl_we_n_o,
  output logic                   reset_powerdown_input_n_o,
  output logic                   write_protect_n_o,
  input  wire logic              ready_busy_output_i
);
  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic rdy_pin;
  fsl_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (ready_busy_output_i),
    .level_o (rdy_pin)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fsl_bus_e              st_q, st_d;
  logic [ADDR_W-1:0]     addr_q, addr_d, taddr_q, taddr_d;
  logic [DATA_W-1:0]     dq_q, dq_d, wdat_q, wdat_d, rdat_q, rdat_d;
  logic                  oe_q, oe_d, ce_n_q, ce_n_d, rd_q, rd_d, we_n_q, we_n_d;
  logic                  oe_n_q, oe_n_d, rp_n_q, wp_n_q;
  logic [3:0]            op_q, op_d;
  logic [1:0]            step_q, step_d;
  logic [2:0]            cnt_q, cnt_d;
  logic [15:0]           gap_q, gap_d;
  logic                  esusp_q, esusp_d, wsusp_q, wsusp_d, wdur_q, wdur_d;
  logic                  rej_q, rej_d, unk_q, unk_d, ack_q, ack_d;
  logic [31:0]           wbd_q, wbd_d;
  logic                  wb_req, is_rd;
  logic [7:0]            cmd;

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;

  // Command byte for the current step of the operation
  always_comb begin
    cmd = CMD_READ_STATUS;
    is_rd = 1'b0;
    case (op_q)
      OP_SUSPEND:    cmd = (step_q == 2'd0) ? CMD_SUSPEND : CMD_READ_STATUS;
      OP_RESUME:     cmd = (step_q == 2'd0) ? CMD_RESUME : CMD_READ_STATUS;
      OP_SET_BLOCK:  cmd = (step_q == 2'd0) ? CMD_LOCK_SETUP : CMD_SET_BLOCK;
      OP_SET_PERM:   cmd = (step_q == 2'd0) ? CMD_LOCK_SETUP : CMD_SET_PERM;
      OP_CLEAR_LOCK: cmd = (step_q == 2'd0) ? CMD_LOCK_SETUP : CMD_CLEAR_LOCKS;
      OP_CLEAR_STAT: cmd = CMD_CLEAR_STATUS;
      OP_WRITE_WORD: cmd = (step_q == 2'd0) ? CMD_WRITE_SETUP : 8'h00;
      OP_READ_ARRAY: cmd = CMD_READ_ARRAY;
      default:       cmd = CMD_READ_STATUS;
    endcase
    // Last step of each operation except clear-status is a read cycle
    case (op_q)
      OP_SUSPEND, OP_RESUME, OP_SET_BLOCK, OP_SET_PERM, OP_CLEAR_LOCK,
      OP_WRITE_WORD: is_rd = (step_q == 2'd2);
      OP_READ_STAT, OP_READ_ARRAY: is_rd = (step_q == 2'd1);
      default:       is_rd = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q; addr_d = addr_q; taddr_d = taddr_q; dq_d = dq_q;
    wdat_d = wdat_q; rdat_d = rdat_q; oe_d = oe_q; ce_n_d = ce_n_q; rd_d = rd_q;
    we_n_d = we_n_q; op_d = op_q; step_d = step_q; cnt_d = cnt_q;
    esusp_d = esusp_q; wsusp_d = wsusp_q; wdur_d = wdur_q; rej_d = rej_q;
    unk_d = unk_q; ack_d = 1'b0; wbd_d = wbd_q;
    gap_d = (gap_q != 16'h0000) ? gap_q - 16'h0001 : gap_q;

    // Register bus: one-cycle answer, ack dropped the cycle after
    if (wb_req) begin
      ack_d = 1'b1;
      wbd_d = 32'h0000_0000;
      if (wb_we_i) begin
        case (wb_adr_i)
          REG_ADDR: taddr_d = wb_dat_i[ADDR_W-1:0];
          REG_DATA: wdat_d = wb_dat_i[DATA_W-1:0];
          REG_CTRL: if (st_q == FSL_IDLE && wb_sel_i[0] &&
                        wb_dat_i[CTRL_OP_W-1:0] != OP_NONE) begin
            rej_d = 1'b0;
            // Suspended modes accept only the listed commands
            if ((esusp_q && !(wb_dat_i[3:0] inside {OP_RESUME, OP_READ_STAT,
                   OP_READ_ARRAY, OP_WRITE_WORD, OP_SUSPEND})) ||
                (wsusp_q && !(wb_dat_i[3:0] inside {OP_RESUME, OP_READ_STAT,
                   OP_READ_ARRAY})) ||
                (wb_dat_i[3:0] == OP_RESUME && esusp_q && wdur_q && !rdy_pin) ||
                (wb_dat_i[3:0] == OP_SUSPEND && gap_q != 16'h0000)) begin
              rej_d = 1'b1;
            end else begin
              op_d   = wb_dat_i[3:0];
              step_d = 2'd0;
              st_d   = FSL_SETUP;
              if (wb_dat_i[3:0] == OP_CLEAR_LOCK) unk_d = 1'b1;
              if (wb_dat_i[3:0] == OP_WRITE_WORD && esusp_q) wdur_d = 1'b1;
            end
          end
          default: ;
        endcase
      end else begin
        case (wb_adr_i)
          REG_ADDR:   wbd_d[ADDR_W-1:0] = taddr_q;
          REG_DATA:   wbd_d[DATA_W-1:0] = rdat_q;
          REG_CTRL:   wbd_d[3:0] = op_q;
          REG_STATUS: begin
            wbd_d[7:0]         = rdat_q[7:0];
            wbd_d[ST_BUSY]     = (st_q != FSL_IDLE);
            wbd_d[ST_SUSP_OK]  = esusp_q | wsusp_q;
            wbd_d[ST_RDY_PIN]  = rdy_pin;
            wbd_d[ST_REJECT]   = rej_q;
            wbd_d[ST_LOCK_UNK] = unk_q;
          end
          default: ;
        endcase
      end
    end

    // Flash bus cycle sequencer
    case (st_q)
      FSL_IDLE: ;
      FSL_SETUP: begin
        addr_d = taddr_q;
        ce_n_d = 1'b0;
        rd_d = is_rd;
        oe_d = !is_rd;
        dq_d = (op_q == OP_WRITE_WORD && step_q == 2'd1) ? wdat_q
               : {{(DATA_W-8){1'b0}}, cmd};
        cnt_d = 3'(STROBE_CYC);
        st_d = FSL_STROBE;
      end
      FSL_STROBE: begin
        we_n_d = rd_q;
        if (cnt_q > 3'd1) cnt_d = cnt_q - 3'd1;
        else begin
          cnt_d = 3'(STROBE_CYC);
          st_d = FSL_HOLD;
        end
      end
      FSL_HOLD: begin
        if (cnt_q > 3'd1) cnt_d = cnt_q - 3'd1;
        else begin
          if (rd_q) rdat_d = fl_dq_i;
          we_n_d = 1'b1; rd_d = 1'b0; ce_n_d = 1'b1; oe_d = 1'b0;
          st_d = FSL_GAP;
        end
      end
      FSL_GAP: begin
        if (rd_q == 1'b0 && !is_rd) begin
          step_d = step_q + 2'd1;
          st_d = FSL_SETUP;
        end else st_d = FSL_SETUP;
        if (is_rd) begin
          // Read just finished; close the operation
          st_d = FSL_IDLE;
          step_d = 2'd0;
          // Confirm suspension from status flags
          if (op_q == OP_SUSPEND) begin
            esusp_d = rdat_q[SR_READY] && rdat_q[SR_ERASE_SUSP];
            wsusp_d = rdat_q[SR_READY] && rdat_q[SR_WRITE_SUSP];
            if (esusp_q) esusp_d = 1'b1;
          end
          if (op_q == OP_RESUME) begin
            gap_d = 16'(RESUME_GAP_CYC);
            if (wsusp_q) wsusp_d = 1'b0;
            else begin
              // A write started in erase suspend is tracked until the erase resumes
              esusp_d = 1'b0;
              wdur_d  = 1'b0;
            end
          end
          // Clear-lock leaves state known only after success
          if (op_q == OP_CLEAR_LOCK && rdat_q[SR_READY] &&
              !rdat_q[SR_ERASE_ERR]) unk_d = 1'b0;
          // Lock state is known only once the engine reports ready, so keep polling
          if (op_q == OP_CLEAR_LOCK && !rdat_q[SR_READY]) begin
            st_d   = FSL_SETUP;
            step_d = step_q;
          end
        end else if (op_q == OP_CLEAR_STAT || op_q == OP_READ_STAT) begin
          // Clear-status is a single write and is ignored by a suspended part
          step_d = step_q + 2'd1;
          if (op_q == OP_CLEAR_STAT) st_d = FSL_IDLE;
        end
      end
      default: st_d = FSL_IDLE;
    endcase
    // Output enable is registered so the pin cannot glitch between phases
    oe_n_d = !rd_d;
  end

  // Error flags come back in rdat bits; lock refusal classes are the device's to report
  // are shown to software through status bits 5:1

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= FSL_IDLE; addr_q <= '0; taddr_q <= '0; dq_q <= RESET_DATA;
      wdat_q <= RESET_DATA; rdat_q <= RESET_DATA; oe_q <= 1'b0; ce_n_q <= 1'b1;
      rd_q <= 1'b0; we_n_q <= 1'b1; op_q <= OP_NONE; step_q <= 2'd0; cnt_q <= 3'd0;
      oe_n_q <= 1'b1; rp_n_q <= 1'b0; wp_n_q <= 1'b1;
      gap_q <= 16'h0000; esusp_q <= 1'b0; wsusp_q <= 1'b0; wdur_q <= 1'b0;
      rej_q <= 1'b0; unk_q <= 1'b0; ack_q <= 1'b0; wbd_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d; addr_q <= addr_d; taddr_q <= taddr_d; dq_q <= dq_d;
      wdat_q <= wdat_d; rdat_q <= rdat_d; oe_q <= oe_d; ce_n_q <= ce_n_d;
      rd_q <= rd_d; we_n_q <= we_n_d; op_q <= op_d; step_q <= step_d; cnt_q <= cnt_d;
      oe_n_q <= oe_n_d; rp_n_q <= 1'b1; wp_n_q <= 1'b1;
      gap_q <= gap_d; esusp_q <= esusp_d; wsusp_q <= wsusp_d; wdur_q <= wdur_d;
      rej_q <= rej_d; unk_q <= unk_d; ack_q <= ack_d; wbd_q <= wbd_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o   = ack_q;
  assign wb_dat_o   = wbd_q;
  assign fl_addr_o  = addr_q;
  assign fl_dq_o    = dq_q;
  assign fl_dq_oe_o = oe_q;
  assign fl_ce_n_o  = ce_n_q;
  assign fl_oe_n_o  = oe_n_q;
  assign fl_we_n_o  = we_n_q;
  // Low only in our own reset and steady otherwise, so a suspended erase is never disturbed
  assign reset_powerdown_input_n_o = rp_n_q;
  assign write_protect_n_o         = wp_n_q;
endmodule // fsl_host

// [fsl_host_checker.sv]
// Checker: port-level timing of the flash host
`timescale 1ns/100ps
module fsl_host_checker import fsl_pkg::*; #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
) (
  // Clock, reset and Wishbone
  input wire logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [3:0]        wb_adr_i, wb_sel_i,
  input wire logic [31:0]       wb_dat_i, wb_dat_o,
  // Flash bus
  input wire logic [ADDR_W-1:0] fl_addr_o,
  input wire logic [DATA_W-1:0] fl_dq_i, fl_dq_o,
  input wire logic              fl_dq_oe_o, fl_ce_n_o, fl_oe_n_o, fl_we_n_o,
  input wire logic              reset_powerdown_input_n_o, write_protect_n_o,
  input wire logic              ready_busy_output_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_RST_IDLE: assert property (disable iff (1'b0) rst_i |=> fl_ce_n_o && fl_we_n_o
    && fl_oe_n_o && !fl_dq_oe_o) else $error("flash bus not idle in reset");
  AST_RP_LOW: assert property (disable iff (1'b0) rst_i ##1 rst_i |->
    !reset_powerdown_input_n_o) else $error("flash reset not driven in reset");
  AST_RP_KEEP: assert property (reset_powerdown_input_n_o |=> reset_powerdown_input_n_o)
    else $error("flash reset dropped outside reset");
  AST_WP_STEADY: assert property ($stable(write_protect_n_o))
    else $error("write protect level changed");
  AST_NO_FIGHT: assert property (!fl_oe_n_o |-> !fl_dq_oe_o && !fl_ce_n_o)
    else $error("host drives data while flash output enabled");
  AST_WE_ALONE: assert property (!fl_we_n_o |-> fl_oe_n_o && !fl_ce_n_o && fl_dq_oe_o)
    else $error("write strobe without select or data");
  AST_WE_WIDTH: assert property ($fell(fl_we_n_o) |-> !fl_we_n_o ##1 !fl_we_n_o)
    else $error("write strobe too short");
  AST_WE_DATA: assert property (!fl_we_n_o && $past(!fl_we_n_o) |->
    $stable(fl_dq_o) && $stable(fl_addr_o)) else $error("data moved during strobe");
  cover property (wb_ack_o && !wb_we_i);
  cover property ($fell(fl_we_n_o));
  cover property (wb_ack_o && wb_dat_o[ST_REJECT]);
endmodule // fsl_host_checker

bind fsl_host fsl_host_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) fsl_host_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .fl_addr_o(fl_addr_o), .fl_dq_i(fl_dq_i),
  .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o), .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o),
  .fl_we_n_o(fl_we_n_o), .reset_powerdown_input_n_o(reset_powerdown_input_n_o),
  .write_protect_n_o(write_protect_n_o), .ready_busy_output_i(ready_busy_output_i));

// [fsl_flash_model.sv]
// Behavioural flash: suspend, resume and lock command handling
`timescale 1ns/100ps
module fsl_flash_model import fsl_pkg::*; #(
  parameter int ELAT = 2000,
  parameter int WLAT = 20
) (
  input  wire logic        clk_i, rp_n_i, ce_n_i, oe_n_i, we_n_i, start_i, supply_low_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  output logic             ready_busy_o
);
  logic [7:0]  err_q = 8'h00;
  logic        esus_q = 0, wsus_q = 0, perm_q = 0, blk_q = 0, stat_q = 0, we_q = 1;
  logic [1:0]  pend_q = 2'h0;
  logic [15:0] last_q = 16'h0000, cmd_q = 16'h0000;
  logic [7:0]  sr, c;
  logic        busy;
  int          ecnt_q = 0, wcnt_q = 0;
  assign c = cmd_q[7:0];
  assign busy = (ecnt_q != 0 && !esus_q) || (wcnt_q != 0 && !wsus_q);
  assign sr = {!busy, esus_q, err_q[5:3], wsus_q, err_q[1], 1'b0};
  assign ready_busy_o = !busy;
  // Released bus shows the inverse of its last value so stale data never looks valid
  assign dq_o = (!ce_n_i && !oe_n_i) ? (stat_q ? {8'h00, sr} : ~addr_i[15:0]) : ~last_q;
  always @(posedge clk_i) begin
    we_q <= we_n_i;
    if (!we_n_i) cmd_q <= dq_i;
    if (!ce_n_i && !oe_n_i) last_q <= dq_o;
    if (ecnt_q != 0 && !esus_q) ecnt_q <= ecnt_q - 1;
    if (wcnt_q != 0 && !wsus_q) wcnt_q <= wcnt_q - 1;
    if (start_i) begin ecnt_q <= ELAT; stat_q <= 1; end
    if (!rp_n_i) begin
      ecnt_q <= 0; wcnt_q <= 0; esus_q <= 0; wsus_q <= 0; pend_q <= 0; err_q <= 0;
    end else if (!we_q && we_n_i) begin
      stat_q <= 1;
      if (pend_q == 2'h1) begin
        pend_q <= 0;
        if (!(c == CMD_SET_BLOCK || c == CMD_SET_PERM || c == CMD_CLEAR_LOCKS))
          err_q <= err_q | 8'h30;
        else if (supply_low_i) err_q <= err_q | (c == CMD_CLEAR_LOCKS ? 8'h28 : 8'h18);
        else if (perm_q && c != CMD_SET_PERM)
          err_q <= err_q | (c == CMD_CLEAR_LOCKS ? 8'h22 : 8'h12);
        else begin
          wcnt_q <= WLAT;
          if (c == CMD_SET_PERM) perm_q <= 1;
          else blk_q <= (c == CMD_SET_BLOCK);
        end
      end else if (pend_q == 2'h2) begin
        pend_q <= 0;
        wcnt_q <= WLAT;
      end else case (c)
        CMD_READ_ARRAY: stat_q <= 0;
        CMD_CLEAR_STATUS: if (!esus_q && !wsus_q) err_q <= 8'h00;
        CMD_SUSPEND: if (wcnt_q != 0 && !wsus_q) wsus_q <= 1;
          else if (ecnt_q != 0 && wcnt_q == 0) esus_q <= 1;
          else stat_q <= 0;
        CMD_RESUME: if (wsus_q) wsus_q <= 0;
          else if (wcnt_q == 0) esus_q <= 0;
        CMD_LOCK_SETUP: if (!esus_q && !wsus_q) pend_q <= 2'h1;
        CMD_WRITE_SETUP: if (!wsus_q) pend_q <= 2'h2;
        default: ;
      endcase
    end
  end
endmodule // fsl_flash_model

// [tb_fsl_host.sv]
// Testbench: flash host over Wishbone against the behavioural flash
`timescale 1ns/100ps
module tb_fsl_host import fsl_pkg::*; ;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, start = 0, sup_low = 0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0000_0000, dat_o, seed = 32'h8796_1763, r;
  logic        ack, ce_n, oe_n, we_n, dq_oe, rp_n, rb;
  logic [19:0] fa;
  logic [15:0] hdq, mdq, fdq;
  logic [63:0] expq[$];
  int          miscompares = 0, compares = 0;
  initial forever #25 clk_i = ~clk_i;
  assign fdq = dq_oe ? hdq : mdq;
  fsl_host #(.ADDR_W(20), .DATA_W(16)) fsl_host_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .fl_addr_o(fa), .fl_dq_i(fdq),
    .fl_dq_o(hdq), .fl_dq_oe_o(dq_oe), .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n), .fl_we_n_o(we_n),
    .reset_powerdown_input_n_o(rp_n), .write_protect_n_o(), .ready_busy_output_i(rb));
  fsl_flash_model #(.WLAT(80)) fsl_flash_model_inst (.clk_i(clk_i), .rp_n_i(rp_n), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .start_i(start), .supply_low_i(sup_low), .addr_i(fa),
    .dq_i(hdq), .dq_o(mdq), .ready_busy_o(rb));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, e);
    compares++;
    if (got !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Bus cycle: request held until the edge that samples ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, m, e);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    if (!w) expq.push_back({m, e});
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    r = dat_o;
    cyc <= 0; stb <= 0;
    if (n >= 50) begin miscompares++; give_verdict; end
  endtask
  task automatic op(input logic [3:0] o);
    int n;
    wb(1, REG_CTRL, {28'h000_0000, o}, '0, '0);
    n = 0;
    do begin wb(0, REG_STATUS, '0, '0, '0); n++; end while (r[ST_BUSY] !== 1'b0 && n < 200);
    if (n >= 200) begin miscompares++; give_verdict; end
  endtask
  task automatic st(input logic [31:0] m, e);
    op(OP_READ_STAT);
    wb(0, REG_STATUS, '0, m, e);
  endtask
  task automatic lk(input logic [3:0] o, input logic [31:0] m, e);
    op(o);
    repeat (100) @(posedge clk_i);
    st(m, e);
  endtask
  // Each read result is matched with the oldest expectation noted by the driver
  always @(posedge clk_i) if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
    logic [63:0] x;
    x = expq.pop_front();
    chk("status", dat_o & x[63:32], x[31:0]);
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    seed = lfsr(seed);
    wb(1, REG_ADDR, seed & 32'h000F_FFFF, '0, '0);
    seed = lfsr(seed);
    wb(1, REG_DATA, seed & 32'h0000_FFFF, '0, '0);
    wb(0, 4'h2, '0, '0, '0);
    start <= 1;
    @(posedge clk_i);
    start <= 0;
    op(OP_SUSPEND);
    st(32'h0000_06C4, 32'h0000_06C0);
    op(OP_WRITE_WORD);
    wb(0, REG_STATUS, '0, 32'h0000_00C0, 32'h0000_0040);
    op(OP_SUSPEND);
    wb(0, REG_STATUS, '0, 32'h0000_02C4, 32'h0000_02C4);
    op(OP_WRITE_WORD);
    wb(0, REG_STATUS, '0, 32'h0000_0800, 32'h0000_0800);
    op(OP_RESUME);
    wb(0, REG_STATUS, '0, 32'h0000_02C4, 32'h0000_0240);
    op(OP_RESUME);
    wb(0, REG_STATUS, '0, 32'h0000_0800, 32'h0000_0800);
    repeat (100) @(posedge clk_i);
    st(32'h0000_00D0, 32'h0000_00C0);
    op(OP_SET_BLOCK);
    wb(0, REG_STATUS, '0, 32'h0000_0800, 32'h0000_0800);
    op(OP_CLEAR_STAT);
    wb(0, REG_STATUS, '0, 32'h0000_0800, 32'h0000_0800);
    op(OP_RESUME);
    st(32'h0000_04C0, 32'h0000_0000);
    op(OP_SUSPEND);
    wb(0, REG_STATUS, '0, 32'h0000_0800, 32'h0000_0800);
    repeat (2100) @(posedge clk_i);
    op(OP_SUSPEND);
    st(32'h0000_02C0, 32'h0000_0080);
    sup_low <= 1;
    lk(OP_CLEAR_LOCK, 32'h0000_103A, 32'h0000_1028);
    sup_low <= 0;
    lk(OP_CLEAR_STAT, 32'h0000_003A, 32'h0000_0000);
    lk(OP_SET_BLOCK, 32'h0000_00BA, 32'h0000_0080);
    lk(OP_CLEAR_LOCK, 32'h0000_10BA, 32'h0000_0080);
    lk(OP_SET_PERM, 32'h0000_00BA, 32'h0000_0080);
    lk(OP_SET_BLOCK, 32'h0000_003A, 32'h0000_0012);
    lk(OP_CLEAR_LOCK, 32'h0000_1022, 32'h0000_1022);
    lk(OP_CLEAR_STAT, 32'h0000_003A, 32'h0000_0000);
    give_verdict;
  end
endmodule // tb_fsl_host
